// ===== logic/cfi_cfg.svh
// Purpose: constants for the CPU flag register and fast interrupt gating
// Assumes: 8-bit core, register file addressed 0..255
// Notes: offsets are register file addresses
`ifndef CFI_CFG_SVH
`define CFI_CFG_SVH
`define CFI_FLAGS_ADDR 8'hd5
`define CFI_FVP_HI_ADDR 8'hda
`define CFI_FVP_LO_ADDR 8'hdb
`define CFI_MODE_ADDR 8'hdf
`define CFI_FLAGS_RST 8'h00
`define CFI_MODE_RST 8'h00
`define CFI_BIT_C 7
`define CFI_BIT_Z 6
`define CFI_BIT_S 5
`define CFI_BIT_V 4
`define CFI_BIT_D 3
`define CFI_BIT_H 2
`define CFI_BIT_FIS 1
`define CFI_BIT_BANK 0
`define CFI_MODE_GIE 0
`define CFI_MODE_FEN 1
`define CFI_MODE_LVL_LO 2
`define CFI_MODE_LVL_HI 4
`endif

// ===== logic/cfi_core.sv
// Purpose: CPU status flags, datapath results and fast interrupt gating
// Assumes: instruction decode outside drives one command per cycle
// Notes: register file writes to the flag, pointer and mode addresses land here
// Operation
// - Fast handling works for hardware-cleared and software-cleared pending sources.
// - The mode register fast enable bit turns fast handling on or off.
// - Global enable and disable instructions gate all interrupts including fast.
// - Bits in a byte are numbered 7 down to 0, bit 0 least.
// - Registers selected by 8-bit address or 4-bit working register address.
// - Two paired registers form one 16-bit data or address value.
// - Any register bit can be set, cleared, complemented and tested.
// - Datapath handles bits, bytes, BCD digits and two-byte words.
// - 16-bit word increment and decrement are single operations.
// - Byte arithmetic includes multiply and divide.
// - Peripheral registers live in the register file; no I/O instructions.
// - Seven addressing modes: register, indirect, indexed, direct, relative, immediate, indirect.
// - Upper four flag bits serve as jump test conditions.
// - Flag bits 3 and 2 hold decimal arithmetic state.
// - Flag bit 1 reads 1 in fast routine, 0 after interrupt return.
// - Flag bit 0 reads 0 for bank 0, 1 for bank 1.
// - Flag register writable by instructions that do not modify flags.
// - AND sets zero and sign flags from its result and clears overflow.
// - Fast status set on fast entry, cleared on return; blocks interrupts, picks fast return.
// - Fast entry swaps pointer and PC, shadows flags; return swaps back, restores.
// - Mode bits 4 to 2 pick the interrupt level for fast handling.
`timescale 1ns/1ps
`include "cfi_cfg.svh"
module cfi_core #(
   parameter int LEVELS = 8
) (
   input wire logic ref_clk_i, // 20 MHz core clock
   input wire logic srst_i, // Synchronous reset, high
   input wire cfi_pkg::cfi_cmd_t cmd_i, // Datapath command
   input wire logic [3:0] cond_i, // Jump condition select
   input wire logic [7:0] wr_addr_i, // Register file write address
   input wire logic [7:0] wr_data_i, // Register file write data
   input wire logic wr_en_i, // Register file write strobe
   input wire logic [3:0] wreg_i, // Working register number
   input wire logic [4:0] wptr_i, // Working register pointer bits
   input wire cfi_pkg::cfi_amode_t amode_i, // Address form
   input wire logic [7:0] raddr_i, // Direct register address
   input wire logic [7:0] pair_hi_i, // Paired register high byte
   input wire logic [7:0] pair_lo_i, // Paired register low byte
   input wire logic gie_on_i, // Global interrupt enable instruction
   input wire logic gie_off_i, // Global interrupt disable instruction
   input wire logic bank0_i, // Bank zero select instruction
   input wire logic bank1_i, // Bank one select instruction
   input wire logic [LEVELS-1:0] irq_req_i, // Qualified request per level
   input wire logic irq_ack_i, // Instruction boundary, take interrupt
   input wire logic interrupt_return_instr_i, // Interrupt return instruction
   input wire logic [15:0] pc_i, // Current program counter
   output cfi_pkg::cfi_flags_t flags_o, // Status flag register
   output logic [7:0] mode_o, // System mode register
   output logic [15:0] fvp_o, // Fast vector pointer
   output cfi_pkg::cfi_res_t res_o, // Datapath result
   output logic [7:0] sel_addr_o, // Selected register address
   output logic [15:0] pair_o, // Paired 16-bit value
   output logic cond_true_o, // Jump condition met
   output logic irq_take_o, // Interrupt accepted this cycle
   output logic fast_take_o, // Accepted interrupt is the fast one
   output logic fast_ret_o, // Return takes the fast path
   output logic pc_load_o, // Load PC with pc_new_o
   output logic [15:0] pc_new_o // New program counter
);
   cfi_pkg::cfi_flags_t flags_q;
   cfi_pkg::cfi_flags_t shadow_q;
   cfi_pkg::cfi_flags_t next_flags;
   logic [7:0] mode_q;
   logic [15:0] fvp_q;
   cfi_pkg::cfi_res_t next_res;
   logic [2:0] fast_lvl;
   logic any_req;
   logic [7:0] fl_vec;

   // Bit number 0 is the least significant position
   function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] n);
      pick_bit = v[n];
   endfunction

   function automatic logic [7:0] mask_of(input logic [2:0] n);
      mask_of = 8'h01 << n;
   endfunction

   assign fast_lvl = mode_q[`CFI_MODE_LVL_HI:`CFI_MODE_LVL_LO];
   assign any_req = |irq_req_i;

   // Pending-bit clearing is outside; fast path depends on accepted take, mode fast enable bit and level
   always_comb
   begin
      irq_take_o = irq_ack_i && any_req && mode_q[`CFI_MODE_GIE] && !flags_q.fast_irq_status_flag;
      fast_take_o = irq_take_o && mode_q[`CFI_MODE_FEN] && irq_req_i[fast_lvl];
      fast_ret_o = interrupt_return_instr_i && flags_q.fast_irq_status_flag;
      pc_load_o = fast_take_o || fast_ret_o;
      pc_new_o = fvp_q;
   end

   // Fast vector pointer swaps with PC on entry and on fast return
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         fvp_q <= 16'h0000;
      else if (fast_take_o || fast_ret_o)
         fvp_q <= pc_i;
      else if (wr_en_i && wr_addr_i == `CFI_FVP_HI_ADDR)
         fvp_q[15:8] <= wr_data_i;
      else if (wr_en_i && wr_addr_i == `CFI_FVP_LO_ADDR)
         fvp_q[7:0] <= wr_data_i;
   end

   // Mode register; global enable cleared on normal entry, set on normal return
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         mode_q <= `CFI_MODE_RST;
      else
      begin
         if (wr_en_i && wr_addr_i == `CFI_MODE_ADDR)
            mode_q <= wr_data_i;
         if (gie_on_i || (interrupt_return_instr_i && !flags_q.fast_irq_status_flag))
            mode_q[`CFI_MODE_GIE] <= 1'b1;
         if (gie_off_i || (irq_take_o && !fast_take_o))
            mode_q[`CFI_MODE_GIE] <= 1'b0;
      end
   end

   // Datapath arithmetic and logic
   always_comb
   begin
      logic [8:0] sum;
      logic [16:0] wsum;
      logic [7:0] lo;
      logic cin;
      sum = 9'h000;
      wsum = 17'h00000;
      lo = 8'h00;
      cin = flags_q.c;
      next_res = '0;
      next_flags = flags_q;
      case (cmd_i.op)
         cfi_pkg::CFI_ADD, cfi_pkg::CFI_ADC:
         begin
            sum = {1'b0, cmd_i.a[7:0]} + {1'b0, cmd_i.b[7:0]}
               + {8'h00, cmd_i.op == cfi_pkg::CFI_ADC && cin};
            lo = sum[7:0];
            next_flags.c = sum[8];
            next_flags.v = (cmd_i.a[7] == cmd_i.b[7]) && (lo[7] != cmd_i.a[7]);
            next_flags.h = (cmd_i.a[3:0] + cmd_i.b[3:0]) > 5'h0f;
            next_flags.d = 1'b0;
         end
         cfi_pkg::CFI_SUB, cfi_pkg::CFI_SBC:
         begin
            sum = {1'b0, cmd_i.a[7:0]} - {1'b0, cmd_i.b[7:0]}
               - {8'h00, cmd_i.op == cfi_pkg::CFI_SBC && cin};
            lo = sum[7:0];
            next_flags.c = sum[8];
            next_flags.v = (cmd_i.a[7] != cmd_i.b[7]) && (lo[7] != cmd_i.a[7]);
            next_flags.h = cmd_i.a[3:0] < cmd_i.b[3:0];
            next_flags.d = 1'b1;
         end
         cfi_pkg::CFI_AND: lo = cmd_i.a[7:0] & cmd_i.b[7:0];
         cfi_pkg::CFI_OR: lo = cmd_i.a[7:0] | cmd_i.b[7:0];
         cfi_pkg::CFI_XOR: lo = cmd_i.a[7:0] ^ cmd_i.b[7:0];
         cfi_pkg::CFI_COM: lo = ~cmd_i.a[7:0];
         cfi_pkg::CFI_INC: lo = cmd_i.a[7:0] + 8'h01;
         cfi_pkg::CFI_DEC: lo = cmd_i.a[7:0] - 8'h01;
         cfi_pkg::CFI_DA:
         begin
            lo = cmd_i.a[7:0];
            if (!flags_q.d)
               lo = lo + ((flags_q.h || lo[3:0] > 4'h9) ? 8'h06 : 8'h00)
                  + ((flags_q.c || cmd_i.a[7:0] > 8'h99) ? 8'h60 : 8'h00);
            else
               lo = lo - (flags_q.h ? 8'h06 : 8'h00) - (flags_q.c ? 8'h60 : 8'h00);
            next_flags.c = flags_q.c || (!flags_q.d && cmd_i.a[7:0] > 8'h99);
         end
         default: lo = 8'h00;
      endcase
      case (cmd_i.op)
         cfi_pkg::CFI_ADD, cfi_pkg::CFI_ADC, cfi_pkg::CFI_SUB, cfi_pkg::CFI_SBC,
         cfi_pkg::CFI_AND, cfi_pkg::CFI_OR, cfi_pkg::CFI_XOR, cfi_pkg::CFI_COM,
         cfi_pkg::CFI_INC, cfi_pkg::CFI_DEC, cfi_pkg::CFI_DA:
         begin
            next_res.res = {8'h00, lo};
            next_res.res_we = 1'b1;
            next_flags.z = lo == 8'h00;
            next_flags.s = lo[7];
            if (cmd_i.op inside {cfi_pkg::CFI_AND, cfi_pkg::CFI_OR,
                                 cfi_pkg::CFI_XOR, cfi_pkg::CFI_COM})
               next_flags.v = 1'b0;
         end
         cfi_pkg::CFI_INCW, cfi_pkg::CFI_DECW:
         begin
            wsum = (cmd_i.op == cfi_pkg::CFI_INCW) ? {1'b0, cmd_i.a} + 17'h00001
               : {1'b0, cmd_i.a} - 17'h00001;
            next_res.res = wsum[15:0];
            next_res.res_we = 1'b1;
            next_res.res_word = 1'b1;
            next_flags.z = wsum[15:0] == 16'h0000;
            next_flags.s = wsum[15];
         end
         cfi_pkg::CFI_MULT:
         begin
            next_res.res = cmd_i.a[7:0] * cmd_i.b[7:0];
            next_res.res_we = 1'b1;
            next_res.res_word = 1'b1;
            next_flags.z = next_res.res == 16'h0000;
            next_flags.s = next_res.res[15];
         end
         cfi_pkg::CFI_DIV:
         begin
            next_res.res_we = 1'b1;
            next_res.res_word = 1'b1;
            if (cmd_i.b[7:0] == 8'h00)
            begin
               next_res.res = 16'hffff;
               next_flags.v = 1'b1;
            end
            else
            begin
               next_res.res = cmd_i.a / {8'h00, cmd_i.b[7:0]};
               next_res.res_hi = cmd_i.a % {8'h00, cmd_i.b[7:0]};
               next_flags.v = 1'b0;
            end
            next_flags.z = next_res.res == 16'h0000;
         end
         cfi_pkg::CFI_BSET, cfi_pkg::CFI_BCLR, cfi_pkg::CFI_BCOM:
         begin
            next_res.res_we = 1'b1;
            case (cmd_i.op)
               cfi_pkg::CFI_BSET: next_res.res = {8'h00, cmd_i.a[7:0] | mask_of(cmd_i.bitn)};
               cfi_pkg::CFI_BCLR: next_res.res = {8'h00, cmd_i.a[7:0] & ~mask_of(cmd_i.bitn)};
               default: next_res.res = {8'h00, cmd_i.a[7:0] ^ mask_of(cmd_i.bitn)};
            endcase
         end
         cfi_pkg::CFI_BTST:
         begin
            next_res.test_bit = pick_bit(cmd_i.a[7:0], cmd_i.bitn);
            next_flags.z = !next_res.test_bit;
         end
         cfi_pkg::CFI_LD:
         begin
            next_res.res = {8'h00, cmd_i.b[7:0]};
            next_res.res_we = 1'b1;
         end
         default: next_res.res_we = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         res_o <= '0;
      else
         res_o <= next_res;
   end

   // Flag register: plain writes, datapath updates, bank and fast interrupt effects
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         flags_q <= `CFI_FLAGS_RST;
         shadow_q <= `CFI_FLAGS_RST;
      end
      else if (fast_take_o)
      begin
         shadow_q <= flags_q;
         flags_q.fast_irq_status_flag <= 1'b1;
      end
      else if (fast_ret_o)
      begin
         flags_q <= shadow_q;
         flags_q.fast_irq_status_flag <= 1'b0;
      end
      else
      begin
         // Flag-updating op aimed at the flag address is undefined; datapath wins
         if (wr_en_i && wr_addr_i == `CFI_FLAGS_ADDR)
            flags_q <= wr_data_i;
         // Bit set, clear and complement leave the flags alone, so a direct write lands
         if (!(cmd_i.op inside {cfi_pkg::CFI_NOP, cfi_pkg::CFI_LD, cfi_pkg::CFI_BSET,
                                cfi_pkg::CFI_BCLR, cfi_pkg::CFI_BCOM}))
            flags_q <= next_flags;
         if (bank0_i)
            flags_q.bank <= 1'b0;
         if (bank1_i)
            flags_q.bank <= 1'b1;
      end
   end

   // Condition codes use only the upper four flags
   assign fl_vec = flags_q;
   always_comb
   begin
      case (cond_i)
         4'h0: cond_true_o = 1'b0;
         4'h8: cond_true_o = 1'b1;
         4'h7: cond_true_o = pick_bit(fl_vec, 3'(`CFI_BIT_C));
         4'hf: cond_true_o = !pick_bit(fl_vec, 3'(`CFI_BIT_C));
         4'h6: cond_true_o = pick_bit(fl_vec, 3'(`CFI_BIT_Z));
         4'he: cond_true_o = !pick_bit(fl_vec, 3'(`CFI_BIT_Z));
         4'h5: cond_true_o = pick_bit(fl_vec, 3'(`CFI_BIT_S));
         4'hd: cond_true_o = !pick_bit(fl_vec, 3'(`CFI_BIT_S));
         4'h4: cond_true_o = pick_bit(fl_vec, 3'(`CFI_BIT_V));
         4'hc: cond_true_o = !pick_bit(fl_vec, 3'(`CFI_BIT_V));
         4'h1: cond_true_o = flags_q.s ^ flags_q.v;
         4'h9: cond_true_o = !(flags_q.s ^ flags_q.v);
         4'h2: cond_true_o = flags_q.z || (flags_q.s ^ flags_q.v);
         4'ha: cond_true_o = !(flags_q.z || (flags_q.s ^ flags_q.v));
         4'h3: cond_true_o = flags_q.c || flags_q.z;
         default: cond_true_o = !(flags_q.c || flags_q.z);
      endcase
   end

   // Register selection and pairing; addressing-mode effective address is upstream
   always_comb
   begin
      sel_addr_o = (amode_i == cfi_pkg::CFI_AM_WREG) ? {wptr_i[4:1], wreg_i} : raddr_i;
      pair_o = {pair_hi_i, pair_lo_i};
   end

   assign flags_o = flags_q;
   assign mode_o = mode_q;
   assign fvp_o = fvp_q;
endmodule

// ===== logic/cfi_pkg.sv
// Purpose: types for the CPU flag and fast interrupt block
// Assumes: used together with cfi_cfg.svh
// Notes: operation codes are the datapath commands of this block
package cfi_pkg;
   typedef enum logic [4:0]
   {
      CFI_NOP = 5'h00, CFI_ADD = 5'h01, CFI_ADC = 5'h02, CFI_SUB = 5'h03,
      CFI_SBC = 5'h04, CFI_AND = 5'h05, CFI_OR = 5'h06, CFI_XOR = 5'h07,
      CFI_INC = 5'h08, CFI_DEC = 5'h09, CFI_INCW = 5'h0a, CFI_DECW = 5'h0b,
      CFI_MULT = 5'h0c, CFI_DIV = 5'h0d, CFI_BSET = 5'h0e, CFI_BCLR = 5'h0f,
      CFI_BCOM = 5'h10, CFI_BTST = 5'h11, CFI_DA = 5'h12, CFI_LD = 5'h13,
      CFI_COM = 5'h14
   } cfi_op_t;
   typedef enum logic [1:0]
   {
      CFI_AM_REG = 2'h0, CFI_AM_WREG = 2'h1
   } cfi_amode_t;
   typedef struct packed
   {
      logic c;
      logic z;
      logic s;
      logic v;
      logic d;
      logic h;
      logic fast_irq_status_flag;
      logic bank;
   } cfi_flags_t;
   typedef struct packed
   {
      cfi_op_t op;
      logic [15:0] a;
      logic [15:0] b;
      logic [2:0] bitn;
      logic [7:0] dst_addr;
   } cfi_cmd_t;
   typedef struct packed
   {
      logic [15:0] res;
      logic [15:0] res_hi;
      logic res_we;
      logic res_word;
      logic test_bit;
   } cfi_res_t;
endpackage

// ===== test/cfi_core_assertions.sv
// Purpose: port-level checks of the flag register and fast interrupt gating
// Assumes: single clock, synchronous active-high reset
// Notes: bound to every cfi_core instance
`timescale 1ns/1ps
`include "cfi_cfg.svh"
module cfi_core_assertions #(
   parameter int LEVELS = 8
) (
   input wire logic ref_clk_i, // Clock
   input wire logic srst_i, // Reset
   input wire cfi_pkg::cfi_cmd_t cmd_i, // Command
   input wire logic [7:0] wr_addr_i, // Write address
   input wire logic [7:0] wr_data_i, // Write data
   input wire logic wr_en_i, // Write strobe
   input wire logic [3:0] wreg_i, // Working register
   input wire logic [4:0] wptr_i, // Pointer bits
   input wire cfi_pkg::cfi_amode_t amode_i, // Address form
   input wire logic bank0_i, // Bank zero
   input wire logic bank1_i, // Bank one
   input wire logic [LEVELS-1:0] irq_req_i, // Requests
   input wire logic irq_ack_i, // Boundary
   input wire logic interrupt_return_instr_i, // Return
   input wire logic [15:0] pc_i, // PC
   input wire cfi_pkg::cfi_flags_t flags_o, // Flags
   input wire logic [7:0] mode_o, // Mode
   input wire logic [15:0] fvp_o, // Fast pointer
   input wire cfi_pkg::cfi_res_t res_o, // Result
   input wire logic [7:0] sel_addr_o, // Selected address
   input wire logic irq_take_o, // Take
   input wire logic fast_take_o, // Fast take
   input wire logic fast_ret_o, // Fast return
   input wire logic pc_load_o, // PC load
   input wire logic [15:0] pc_new_o // New PC
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);
   sequence s_fast_go;
      fast_take_o && pc_load_o && pc_new_o == fvp_o;
   endsequence
   sequence s_fast_in;
      flags_o.fast_irq_status_flag && fvp_o == $past(pc_i);
   endsequence
   property p_take_gate;
      irq_take_o |-> irq_ack_i && (|irq_req_i) && mode_o[0] && !flags_o.fast_irq_status_flag;
   endproperty
   a_take_gate: assert property (p_take_gate) else $error("take not gated");
   property p_fast_sel;
      fast_take_o |-> irq_take_o && mode_o[1] && irq_req_i[mode_o[4:2]];
   endproperty
   a_fast_sel: assert property (p_fast_sel) else $error("fast take wrong");
   property p_fast_entry;
      fast_take_o |-> s_fast_go ##1 s_fast_in;
   endproperty
   a_fast_entry: assert property (p_fast_entry) else $error("fast entry wrong");
   property p_fast_ret;
      interrupt_return_instr_i && flags_o.fast_irq_status_flag |-> fast_ret_o ##1 !flags_o.fast_irq_status_flag;
   endproperty
   a_fast_ret: assert property (p_fast_ret) else $error("fast return wrong");
   property p_bank;
      (bank0_i ^ bank1_i) |=> flags_o.bank == $past(bank1_i);
   endproperty
   a_bank: assert property (p_bank) else $error("bank flag wrong");
   property p_and;
      cmd_i.op == cfi_pkg::CFI_AND |=> res_o.res[7:0] == $past(cmd_i.a[7:0] & cmd_i.b[7:0])
         && flags_o.z == (res_o.res[7:0] == 8'h00) && flags_o.s == res_o.res[7] && !flags_o.v;
   endproperty
   a_and: assert property (p_and) else $error("and flags wrong");
   property p_flag_wr;
      wr_en_i && wr_addr_i == `CFI_FLAGS_ADDR
         && cmd_i.op inside {cfi_pkg::CFI_NOP, cfi_pkg::CFI_LD, cfi_pkg::CFI_BSET,
                             cfi_pkg::CFI_BCLR, cfi_pkg::CFI_BCOM}
         && !bank0_i && !bank1_i && !fast_take_o && !(interrupt_return_instr_i && flags_o.fast_irq_status_flag)
         |=> flags_o == $past(wr_data_i);
   endproperty
   a_flag_wr: assert property (p_flag_wr) else $error("flag write lost");
   property p_wsel;
      amode_i == cfi_pkg::CFI_AM_WREG |-> sel_addr_o == {wptr_i[4:1], wreg_i};
   endproperty
   a_wsel: assert property (p_wsel) else $error("working address wrong");
endmodule
bind cfi_core cfi_core_assertions #(.LEVELS(LEVELS)) u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
   .cmd_i(cmd_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
   .wreg_i(wreg_i), .wptr_i(wptr_i), .amode_i(amode_i), .bank0_i(bank0_i), .bank1_i(bank1_i),
   .irq_req_i(irq_req_i), .irq_ack_i(irq_ack_i), .interrupt_return_instr_i(interrupt_return_instr_i), .pc_i(pc_i),
   .flags_o(flags_o), .mode_o(mode_o), .fvp_o(fvp_o), .res_o(res_o), .sel_addr_o(sel_addr_o),
   .irq_take_o(irq_take_o), .fast_take_o(fast_take_o), .fast_ret_o(fast_ret_o),
   .pc_load_o(pc_load_o), .pc_new_o(pc_new_o));

// ===== test/tb_top.sv
// Purpose: directed bench for the flag register and fast interrupt block
// Assumes: inputs change on the falling edge
// Notes: each scenario checks its own results
`timescale 1ns/1ps
`include "cfi_cfg.svh"
`define CHK(nm, e, g) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module tb_top;
   logic ref_clk_i = 1'b0, srst_i = 1'b1, wr_en_i = 1'b0, gie_on_i = 1'b0, gie_off_i = 1'b0;
   logic bank0_i = 1'b0, bank1_i = 1'b0, irq_ack_i = 1'b0, interrupt_return_instr_i = 1'b0;
   logic [3:0] cond_i = 4'h0, wreg_i = 4'h0;
   logic [4:0] wptr_i = 5'h00;
   logic [7:0] wr_addr_i = 8'h00, wr_data_i = 8'h00, raddr_i = 8'h00, irq_req_i = 8'h00;
   logic [7:0] pair_hi_i = 8'h00, pair_lo_i = 8'h00, mode_o, sel_addr_o;
   logic [15:0] pc_i = 16'h0000, fvp_o, pair_o, pc_new_o;
   logic cond_true_o, irq_take_o, fast_take_o, fast_ret_o, pc_load_o;
   cfi_pkg::cfi_cmd_t cmd_i = '0;
   cfi_pkg::cfi_amode_t amode_i = cfi_pkg::CFI_AM_REG;
   cfi_pkg::cfi_flags_t flags_o;
   cfi_pkg::cfi_res_t res_o;
   int miscompares = 0, check_count = 0, cycles = 0;
   cfi_core #(.LEVELS(8)) u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_i(cmd_i),
      .cond_i(cond_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
      .wreg_i(wreg_i), .wptr_i(wptr_i), .amode_i(amode_i), .raddr_i(raddr_i),
      .pair_hi_i(pair_hi_i), .pair_lo_i(pair_lo_i), .gie_on_i(gie_on_i), .gie_off_i(gie_off_i),
      .bank0_i(bank0_i), .bank1_i(bank1_i), .irq_req_i(irq_req_i), .irq_ack_i(irq_ack_i),
      .interrupt_return_instr_i(interrupt_return_instr_i), .pc_i(pc_i), .flags_o(flags_o), .mode_o(mode_o), .fvp_o(fvp_o),
      .res_o(res_o), .sel_addr_o(sel_addr_o), .pair_o(pair_o), .cond_true_o(cond_true_o),
      .irq_take_o(irq_take_o), .fast_take_o(fast_take_o), .fast_ret_o(fast_ret_o),
      .pc_load_o(pc_load_o), .pc_new_o(pc_new_o));
   always #25 ref_clk_i = ~ref_clk_i;
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      wr_en_i = 1'b1;
      wr_addr_i = a;
      wr_data_i = d;
      @(negedge ref_clk_i);
      wr_en_i = 1'b0;
   endtask
   task automatic op(input cfi_pkg::cfi_op_t o, input logic [15:0] a, b, input logic [2:0] n);
      @(negedge ref_clk_i);
      cmd_i.op = o;
      cmd_i.a = a;
      cmd_i.b = b;
      cmd_i.bitn = n;
      @(negedge ref_clk_i);
      cmd_i.op = cfi_pkg::CFI_NOP;
   endtask
   task automatic t_regs();
      `CHK("flags reset", 8'h00, flags_o);
      `CHK("mode reset", 8'h00, mode_o);
      wr(`CFI_FLAGS_ADDR, 8'h81);
      `CHK("flags write", 8'h81, flags_o);
      wr(8'h10, 8'h3c);
      `CHK("flags kept", 8'h81, flags_o);
      cond_i = 4'h7;
      #1 `CHK("cond carry", 1'b1, cond_true_o);
      cond_i = 4'hf;
      #1 `CHK("cond no carry", 1'b0, cond_true_o);
   endtask
   task automatic t_alu();
      wr(`CFI_FLAGS_ADDR, 8'h10);
      op(cfi_pkg::CFI_AND, 16'h0080, 16'h0080, 3'h0);
      `CHK("and res", 16'h0080, res_o.res);
      `CHK("and flags", 3'b010, {flags_o.z, flags_o.s, flags_o.v});
      op(cfi_pkg::CFI_AND, 16'h000f, 16'h00f0, 3'h0);
      `CHK("and zero", 3'b100, {flags_o.z, flags_o.s, flags_o.v});
      op(cfi_pkg::CFI_INCW, 16'hffff, 16'h0000, 3'h0);
      `CHK("incw", 16'h0000, res_o.res);
      op(cfi_pkg::CFI_DECW, 16'h0000, 16'h0000, 3'h0);
      `CHK("decw", 16'hffff, res_o.res);
      op(cfi_pkg::CFI_DIV, 16'h0012, 16'h0000, 3'h0);
      `CHK("div zero", 17'h1ffff, {flags_o.v, res_o.res});
      op(cfi_pkg::CFI_BSET, 16'h0000, 16'h0000, 3'h7);
      `CHK("bit set", 16'h0080, res_o.res);
      op(cfi_pkg::CFI_BTST, 16'h0080, 16'h0000, 3'h0);
      `CHK("bit test", 1'b0, res_o.test_bit);
      op(cfi_pkg::CFI_ADD, 16'h0015, 16'h0027, 3'h0);
      `CHK("add", 18'h0003c, {flags_o.d, flags_o.h, res_o.res});
      op(cfi_pkg::CFI_DA, 16'h003c, 16'h0000, 3'h0);
      `CHK("da add", 16'h0042, res_o.res);
      op(cfi_pkg::CFI_SUB, 16'h0010, 16'h0001, 3'h0);
      `CHK("sub", 18'h3000f, {flags_o.d, flags_o.h, res_o.res});
      op(cfi_pkg::CFI_DA, 16'h000f, 16'h0000, 3'h0);
      `CHK("da sub", 16'h0009, res_o.res);
      op(cfi_pkg::CFI_MULT, 16'h0012, 16'h0010, 3'h0);
      `CHK("mult", 16'h0120, res_o.res);
      op(cfi_pkg::CFI_DIV, 16'h0123, 16'h0010, 3'h0);
      `CHK("div", 32'h00030012, {res_o.res_hi, res_o.res});
      op(cfi_pkg::CFI_BCLR, 16'h00ff, 16'h0000, 3'h3);
      `CHK("bit clear", 16'h00f7, res_o.res);
      op(cfi_pkg::CFI_BCOM, 16'h0005, 16'h0000, 3'h0);
      `CHK("bit complement", 16'h0004, res_o.res);
      @(negedge ref_clk_i);
      wr_en_i = 1'b1;
      wr_addr_i = `CFI_FLAGS_ADDR;
      wr_data_i = 8'h44;
      cmd_i.op = cfi_pkg::CFI_BSET;
      @(negedge ref_clk_i);
      wr_en_i = 1'b0;
      cmd_i.op = cfi_pkg::CFI_NOP;
      `CHK("write beside bit op", 8'h44, flags_o);
   endtask
   task automatic t_misc();
      @(negedge ref_clk_i);
      bank1_i = 1'b1;
      amode_i = cfi_pkg::CFI_AM_WREG;
      wptr_i = 5'h1b;
      wreg_i = 4'h5;
      pair_hi_i = 8'hab;
      pair_lo_i = 8'hcd;
      #1 `CHK("work addr", 8'hd5, sel_addr_o);
      `CHK("pair", 16'habcd, pair_o);
      @(negedge ref_clk_i);
      bank1_i = 1'b0;
      `CHK("bank one", 1'b1, flags_o.bank);
      bank0_i = 1'b1;
      @(negedge ref_clk_i);
      bank0_i = 1'b0;
      `CHK("bank zero", 1'b0, flags_o.bank);
      amode_i = cfi_pkg::CFI_AM_REG;
      raddr_i = 8'h3a;
      #1 `CHK("direct addr", 8'h3a, sel_addr_o);
   endtask
   task automatic t_fast();
      wr(`CFI_FVP_HI_ADDR, 8'h12);
      wr(`CFI_FVP_LO_ADDR, 8'h34);
      wr(`CFI_MODE_ADDR, 8'h0b);
      wr(`CFI_FLAGS_ADDR, 8'h01);
      @(negedge ref_clk_i);
      pc_i = 16'habcd;
      irq_req_i = 8'h04;
      irq_ack_i = 1'b1;
      #1 `CHK("fast take", 3'b111, {irq_take_o, fast_take_o, pc_load_o});
      `CHK("fast vector", 16'h1234, pc_new_o);
      @(negedge ref_clk_i);
      `CHK("fast status", 8'h03, flags_o);
      `CHK("pointer swap", 16'habcd, fvp_o);
      #1 `CHK("inhibit", 1'b0, irq_take_o);
      irq_ack_i = 1'b0;
      interrupt_return_instr_i = 1'b1;
      pc_i = 16'h5678;
      #1 `CHK("fast ret", 1'b1, fast_ret_o);
      @(negedge ref_clk_i);
      interrupt_return_instr_i = 1'b0;
      `CHK("flags back", 8'h01, flags_o);
      `CHK("pointer back", 16'h5678, fvp_o);
      wr(`CFI_FVP_HI_ADDR, 8'h12);
      wr(`CFI_FVP_LO_ADDR, 8'h34);
      `CHK("pointer reload", 16'h1234, fvp_o);
      irq_req_i = 8'h08;
      irq_ack_i = 1'b1;
      #1 `CHK("normal take", 2'b10, {irq_take_o, fast_take_o});
      @(negedge ref_clk_i);
      `CHK("gie cleared", 8'h0a, mode_o);
      #1 `CHK("gie off", 1'b0, irq_take_o);
      irq_ack_i = 1'b0;
      gie_on_i = 1'b1;
      @(negedge ref_clk_i);
      gie_on_i = 1'b0;
      `CHK("gie on", 8'h0b, mode_o);
      wr(`CFI_MODE_ADDR, 8'h09);
      irq_req_i = 8'h04;
      irq_ack_i = 1'b1;
      #1 `CHK("fast off", 2'b10, {irq_take_o, fast_take_o});
      @(negedge ref_clk_i);
      irq_ack_i = 1'b0;
      interrupt_return_instr_i = 1'b1;
      @(negedge ref_clk_i);
      interrupt_return_instr_i = 1'b0;
      `CHK("interrupt_return_instr gie", 8'h09, mode_o);
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      srst_i = 1'b0;
      t_regs();
      t_alu();
      t_misc();
      t_fast();
      complete_run();
   end
endmodule
